// File: common/ccs_cnt_if.sv
// Control and value bundle between the sync controller and one counter.
// Assumes both ends share the system clock.
interface ccs_cnt_if;
  import ccs_pkg::*;
  logic advance;
  logic clear;
  logic load;
  logic [CNT_W-1:0] load_value;
  logic run;
  logic hold;
  logic [CNT_W-1:0] value;

  modport ctrl (output advance, clear, load, load_value, run, hold, input value);
  modport cnt (input advance, clear, load, load_value, run, hold, output value);
endinterface

// File: common/ccs_pkg.sv
// Constants and types shared by the chained clock sync block.
// Assumes one 50 MHz system clock; cable pins arrive asynchronously.
//
// Operation
// - Master sync clears accepting counters on all boards
// - Sync request always runs on master or isolated
// - Sync request on slave refused, error flagged
// - Chain role reported as one of four
// - Master shows whether cable clock is forwarded
// - Slave shows cable-driven or local ticking
// - Flag cable clock absent error
// - Flag cable clock halted error
// - Follow bit makes counter use cable clock
// - Accept bit lets chain clear reset counter
// - Counter advances only while run set
// - Hold bit keeps value when counter stopped
// - Stop and start each counter independently
// - Isolate or connect each counter independently
// - Master can disable and enable cable forwarding
// - Tick counter 64 bits, one per 400 ns
// - Second counter holds seconds and nanoseconds
// - Connected counters stop while forwarding disabled
package ccs_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_PERIOD_NS = 400;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_TICK_CYCLES = TICK_CYCLES / 2;
  // Four missing cable periods declare the clock gone
  localparam int CABLE_TIMEOUT_NS = 1600;
  localparam int CABLE_TIMEOUT_CYCLES = CABLE_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 8;
  localparam int WDOG_W = 8;

  // ==========================================================================
  // Counter layout
  localparam int CNT_W = 64;
  localparam int NS_W = 32;
  localparam int SEC_LSB = 32;
  localparam int N_CNT = 2;
  localparam int CNT_TICK = 0;
  localparam int CNT_POSIX = 1;
  localparam logic [NS_W-1:0] NS_STEP = 32'h0000_0190;
  localparam logic [NS_W-1:0] NS_PER_SEC = 32'h3b9a_ca00;

  // ==========================================================================
  // Reset values
  localparam logic RST_RUN = 1'b1;
  localparam logic RST_FOLLOW = 1'b1;
  localparam logic RST_ACCEPT = 1'b1;
  localparam logic RST_HOLD = 1'b0;
  localparam logic RST_FWD_EN = 1'b1;

  // ==========================================================================
  // Enumerations
  typedef enum logic [1:0] {
    ROLE_MASTER = 2'b00,
    ROLE_PASS = 2'b01,
    ROLE_FINAL = 2'b10,
    ROLE_ISOLATED = 2'b11
  } ccs_role_t;

  typedef enum logic [2:0] {
    CMD_STOP = 3'b000,
    CMD_START = 3'b001,
    CMD_UPDATE = 3'b010,
    CMD_ISOLATE = 3'b011,
    CMD_CONNECT = 3'b100,
    CMD_HOLD_ON = 3'b101,
    CMD_HOLD_OFF = 3'b110,
    CMD_NONE = 3'b111
  } ccs_cmd_t;

  typedef enum logic [1:0] {
    CBL_WAIT = 2'b00,
    CBL_ABSENT = 2'b01,
    CBL_LIVE = 2'b10,
    CBL_HALTED = 2'b11
  } ccs_cbl_t;

endpackage

// File: logic/ccs_chain_sync.sv
// Chain role, cable clock and clear handling for the two timestamp counters.
// Assumes cable pins and the role strap are asynchronous to clock_in;
// command inputs are one-cycle pulses from logic on clock_in.
module ccs_chain_sync import ccs_pkg::*; (
  input wire logic clock_in, // System clock, 50 MHz
  input wire logic rst_in, // Async reset, active high
  input wire logic [1:0] role_in, // Chain role strap
  input wire logic cable_clk_in, // Cable clock from upstream
  input wire logic cable_clr_in, // Cable clear from upstream
  output logic cable_clk_out, // Cable clock downstream
  output logic cable_clr_out, // Cable clear downstream
  input wire logic sync_req_in, // Sync request pulse
  input wire logic fwd_disable_in, // Stop cable forwarding pulse
  input wire logic fwd_enable_in, // Resume cable forwarding pulse
  input wire logic cmd_valid_in, // Counter command strobe
  input wire logic [2:0] cmd_in, // Counter command code
  input wire logic cmd_sel_in, // 0 tick, 1 seconds/ns
  input wire logic [CNT_W-1:0] load_value_in, // Value for update
  output logic [1:0] role_out, // Synchronised chain role
  output logic sync_err_out, // Refused sync pulse
  output logic cable_enabled_out, // Cable clock in use
  output logic chain_clock_absent_err_out, // Cable clock never seen
  output logic chain_clock_halted_err_out, // Cable clock stopped
  output logic [N_CNT-1:0] follow_out, // Follow cable clock bits
  output logic [N_CNT-1:0] accept_out, // Accept chain clear bits
  output logic [N_CNT-1:0] run_out, // Run bits
  output logic [N_CNT-1:0] hold_out, // Hold on stop bits
  output logic [CNT_W-1:0] tick_value_out, // Tick counter
  output logic [CNT_W-1:0] posix_value_out // Seconds/ns counter
);

  initial begin
    if (TICK_CYCLES < 2 || TICK_CYCLES >= (1 << DIV_W)) begin
      $error("Tick divider does not fit");
    end
    if (CABLE_TIMEOUT_CYCLES <= TICK_CYCLES || CABLE_TIMEOUT_CYCLES >= (1 << WDOG_W)) begin
      $error("Cable timeout out of range");
    end
  end

  // ==========================================================================
  // Input synchronisers
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic clk_prev;
  logic clr_prev;
  ccs_role_t role;
  logic is_slave;
  logic cable_rise;
  logic cable_clr_rise;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
      clk_prev <= 1'b0;
      clr_prev <= 1'b0;
    end else begin
      sync_a <= {role_in, cable_clk_in, cable_clr_in};
      sync_b <= sync_a;
      clk_prev <= sync_b[1];
      clr_prev <= sync_b[0];
    end
  end

  assign role = ccs_role_t'(sync_b[3:2]);
  assign is_slave = (role == ROLE_PASS) || (role == ROLE_FINAL);
  assign cable_rise = sync_b[1] && !clk_prev;
  assign cable_clr_rise = sync_b[0] && !clr_prev;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      role_out <= 2'h3;
    end else begin
      role_out <= role;
    end
  end

  // ==========================================================================
  // Local common clock
  logic [DIV_W-1:0] div;
  logic local_tick;

  assign local_tick = (div == DIV_W'(TICK_CYCLES - 1));

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      div <= '0;
    end else if (local_tick) begin
      div <= '0;
    end else begin
      div <= div + DIV_W'(1);
    end
  end

  // ==========================================================================
  // Forwarding enable
  logic fwd_en;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      fwd_en <= RST_FWD_EN;
    end else if (fwd_disable_in) begin
      fwd_en <= 1'b0;
    end else if (fwd_enable_in) begin
      fwd_en <= 1'b1;
    end
  end

  // ==========================================================================
  // Sync request
  logic sync_go;
  logic [DIV_W-1:0] clr_hold;

  assign sync_go = sync_req_in && !is_slave;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sync_err_out <= 1'b0;
    end else begin
      sync_err_out <= sync_req_in && is_slave;
    end
  end

  // Clear stays up a full period so slow slaves sample it
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      clr_hold <= '0;
    end else if (sync_go && role == ROLE_MASTER) begin
      clr_hold <= DIV_W'(TICK_CYCLES);
    end else if (clr_hold != '0) begin
      clr_hold <= clr_hold - DIV_W'(1);
    end
  end

  // ==========================================================================
  // Cable outputs
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cable_clk_out <= 1'b0;
      cable_clr_out <= 1'b0;
    end else begin
      case (role)
        ROLE_MASTER: begin
          cable_clk_out <= fwd_en && (div < DIV_W'(HALF_TICK_CYCLES));
          cable_clr_out <= (clr_hold != '0);
        end
        ROLE_PASS: begin
          cable_clk_out <= sync_b[1];
          cable_clr_out <= sync_b[0];
        end
        default: begin
          cable_clk_out <= 1'b0;
          cable_clr_out <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Cable clock watchdog
  ccs_cbl_t cbl;
  ccs_cbl_t next_cbl;
  logic [WDOG_W-1:0] wdog;
  logic wdog_done;

  assign wdog_done = (wdog == WDOG_W'(CABLE_TIMEOUT_CYCLES - 1));

  always_comb begin
    next_cbl = cbl;
    case (cbl)
      CBL_WAIT: begin
        if (cable_rise) begin
          next_cbl = CBL_LIVE;
        end else if (wdog_done) begin
          next_cbl = CBL_ABSENT;
        end
      end
      CBL_ABSENT: begin
        if (cable_rise) begin
          next_cbl = CBL_LIVE;
        end
      end
      CBL_LIVE: begin
        if (!cable_rise && wdog_done) begin
          next_cbl = CBL_HALTED;
        end
      end
      CBL_HALTED: begin
        if (cable_rise) begin
          next_cbl = CBL_LIVE;
        end
      end
      default: begin
        next_cbl = CBL_WAIT;
      end
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cbl <= CBL_WAIT;
    end else begin
      cbl <= next_cbl;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wdog <= '0;
    end else if (cable_rise || wdog_done) begin
      wdog <= '0;
    end else begin
      wdog <= wdog + WDOG_W'(1);
    end
  end

  // Once a cable clock has been seen, its loss stops followers
  logic cable_seen;
  assign cable_seen = (cbl == CBL_LIVE) || (cbl == CBL_HALTED);

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      chain_clock_absent_err_out <= 1'b0;
      chain_clock_halted_err_out <= 1'b0;
      cable_enabled_out <= 1'b0;
    end else begin
      chain_clock_absent_err_out <= is_slave && (cbl == CBL_ABSENT);
      chain_clock_halted_err_out <= is_slave ? (cbl == CBL_HALTED)
                                             : (role == ROLE_MASTER) && !fwd_en;
      if (is_slave) begin
        cable_enabled_out <= (cbl == CBL_LIVE) && (follow_out != '0);
      end else begin
        cable_enabled_out <= fwd_en;
      end
    end
  end

  // ==========================================================================
  // Per-counter control
  ccs_cnt_if cnt_if [N_CNT] ();

  for (genvar g = 0; g < N_CNT; g++) begin : g_cnt
    logic hit;
    assign hit = cmd_valid_in && (cmd_sel_in == 1'(g));

    always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
        run_out[g] <= RST_RUN;
        follow_out[g] <= RST_FOLLOW;
        accept_out[g] <= RST_ACCEPT;
        hold_out[g] <= RST_HOLD;
      end else if (hit) begin
        case (ccs_cmd_t'(cmd_in))
          CMD_STOP: run_out[g] <= 1'b0;
          CMD_START: run_out[g] <= 1'b1;
          CMD_ISOLATE: begin
            follow_out[g] <= 1'b0;
            accept_out[g] <= 1'b0;
          end
          CMD_CONNECT: begin
            follow_out[g] <= 1'b1;
            accept_out[g] <= 1'b1;
          end
          CMD_HOLD_ON: hold_out[g] <= 1'b1;
          CMD_HOLD_OFF: hold_out[g] <= 1'b0;
          default: begin
          end
        endcase
      end
    end

    always_comb begin
      cnt_if[g].advance = local_tick;
      if (follow_out[g]) begin
        if (role == ROLE_MASTER) begin
          cnt_if[g].advance = local_tick && fwd_en;
        end else if (is_slave && cable_seen) begin
          cnt_if[g].advance = cable_rise;
        end
      end
    end

    assign cnt_if[g].clear = accept_out[g] && (is_slave ? cable_clr_rise : sync_go);
    assign cnt_if[g].load = hit && (ccs_cmd_t'(cmd_in) == CMD_UPDATE);
    assign cnt_if[g].load_value = load_value_in;
    assign cnt_if[g].run = run_out[g];
    assign cnt_if[g].hold = hold_out[g];

    ccs_counter #(
      .SEC_NS(g == CNT_POSIX)
    ) u_counter (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .port_if(cnt_if[g])
    );
  end

  assign tick_value_out = cnt_if[CNT_TICK].value;
  assign posix_value_out = cnt_if[CNT_POSIX].value;

endmodule // ccs_chain_sync

// File: logic/ccs_counter.sv
// One 64-bit timestamp counter, plain tick or seconds/nanoseconds form.
// Assumes advance is a one-cycle pulse per common clock period.
module ccs_counter import ccs_pkg::*; #(
  parameter bit SEC_NS = 1'b0
) (
  input wire logic clock_in, // System clock
  input wire logic rst_in, // Async reset, active high
  ccs_cnt_if.cnt port_if // Control and value
);

  logic [NS_W-1:0] ns_sum;
  logic ns_wrap;

  assign ns_sum = port_if.value[NS_W-1:0] + NS_STEP;
  assign ns_wrap = (ns_sum >= NS_PER_SEC);

  // ==========================================================================
  // Counting
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      port_if.value <= '0;
    end else if (port_if.clear) begin
      port_if.value <= '0;
    end else if (port_if.load) begin
      port_if.value <= port_if.load_value;
    end else if (!port_if.run && !port_if.hold) begin
      port_if.value <= '0;
    end else if (port_if.run && port_if.advance) begin
      if (SEC_NS) begin
        if (ns_wrap) begin
          port_if.value[CNT_W-1:SEC_LSB] <= port_if.value[CNT_W-1:SEC_LSB] + 32'h0000_0001;
          port_if.value[NS_W-1:0] <= ns_sum - NS_PER_SEC;
        end else begin
          port_if.value[NS_W-1:0] <= ns_sum;
        end
      end else begin
        port_if.value <= port_if.value + 64'h0000_0000_0000_0001;
      end
    end
  end

endmodule // ccs_counter

// File: test/ccs_chain_sync_props.sv
// Port-level assertions for the chain sync controller.
// Assumes it is bound onto ccs_chain_sync and sees only its ports.
module ccs_chain_sync_props import ccs_pkg::*; (
  input wire logic clock_in, // System clock
  input wire logic rst_in, // Async reset
  input wire logic [1:0] role_out, // Role
  input wire logic sync_req_in, // Sync request
  input wire logic sync_err_out, // Sync refused
  input wire logic [N_CNT-1:0] accept_out, // Accept bits
  input wire logic [N_CNT-1:0] run_out, // Run bits
  input wire logic [N_CNT-1:0] hold_out, // Hold bits
  input wire logic [CNT_W-1:0] tick_value_out, // Tick count
  input wire logic cable_clr_out, // Clear downstream
  input wire logic cmd_valid_in, // Command strobe
  input wire logic [2:0] cmd_in, // Command code
  input wire logic cmd_sel_in, // Counter select
  input wire logic [CNT_W-1:0] load_value_in, // Load value
  input wire logic fwd_disable_in, // Forwarding off
  input wire logic fwd_enable_in, // Forwarding on
  input wire logic cable_enabled_out, // Cable in use
  input wire logic chain_clock_halted_err_out // Halted error
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // ==================================
  // Properties
  a_sync_refused: assert property (
    sync_req_in && role_out inside {2'b01, 2'b10} |=> sync_err_out)
    else $error("slave sync not refused");
  a_sync_clears: assert property (
    sync_req_in && role_out == 2'b00 && accept_out[0] |=> tick_value_out == 0 ##1 cable_clr_out)
    else $error("master sync did not clear");
  a_clear_width: assert property (
    $rose(cable_clr_out) && role_out == 2'b00 |-> cable_clr_out [*8])
    else $error("chain clear too short");
  a_update_loads: assert property (
    cmd_valid_in && cmd_in == CMD_UPDATE && !cmd_sel_in && !sync_req_in
    |=> tick_value_out == $past(load_value_in))
    else $error("update not loaded");
  a_stop_zeroes: assert property (
    !run_out[0] && !hold_out[0] && !cmd_valid_in && !sync_req_in |=> tick_value_out == 0)
    else $error("stopped count not zeroed");
  a_hold_keeps: assert property (
    !run_out[0] && hold_out[0] && !cmd_valid_in && !sync_req_in |=> $stable(tick_value_out))
    else $error("held count moved");
  a_tick_step: assert property (
    !cmd_valid_in && !sync_req_in
    |=> tick_value_out - $past(tick_value_out) <= 64'h1 || tick_value_out == 0)
    else $error("tick step not one");
  a_fwd_off: assert property (
    fwd_disable_in && role_out == 2'b00 |=> ##1 !cable_enabled_out && chain_clock_halted_err_out)
    else $error("forwarding not disabled");
  a_fwd_on: assert property (
    fwd_enable_in && !fwd_disable_in && role_out == 2'b00 |=> ##1 cable_enabled_out)
    else $error("forwarding not enabled");
  cover property (sync_req_in && role_out == 2'b01);
  cover property (fwd_disable_in && role_out == 2'b00);
  cover property (cmd_valid_in && cmd_in == CMD_UPDATE);
endmodule // ccs_chain_sync_props

bind ccs_chain_sync ccs_chain_sync_props chk_u (
  .clock_in(clock_in), .rst_in(rst_in), .role_out(role_out),
  .sync_req_in(sync_req_in), .sync_err_out(sync_err_out), .accept_out(accept_out),
  .run_out(run_out), .hold_out(hold_out), .tick_value_out(tick_value_out),
  .cable_clr_out(cable_clr_out), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
  .cmd_sel_in(cmd_sel_in), .load_value_in(load_value_in),
  .fwd_disable_in(fwd_disable_in), .fwd_enable_in(fwd_enable_in),
  .cable_enabled_out(cable_enabled_out),
  .chain_clock_halted_err_out(chain_clock_halted_err_out)
);

// File: test/ccs_up_board.sv
// Behavioural upstream master board driving the cable pins.
// Assumes the bench starts and stops its clock and asks for clears.
module ccs_up_board (
  input wire logic run_in, // Cable clock runs
  input wire logic clr_req_in, // Issue chain clear
  output logic cable_clk_out, // Cable clock
  output logic cable_clr_out // Cable clear
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cable_clk_out = 1'b0;
  initial cable_clr_out = 1'b0;
  always #80 cable_clk_out = run_in ? ~cable_clk_out : 1'b0;
  always @(posedge clr_req_in) begin
    cable_clr_out = 1'b1;
    #400 cable_clr_out = 1'b0;
  end
endmodule // ccs_up_board

// File: test/testbench.sv
// Self-checking bench for ccs_chain_sync with an upstream board model.
// Assumes inputs change on falling edges; design samples on rising.
module testbench import ccs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in, rst_in, cable_clk_in, cable_clr_in, sync_req_in, fwd_disable_in;
  logic fwd_enable_in, cmd_valid_in, cmd_sel_in, up_run, up_clr;
  logic cable_clk_out, cable_clr_out, sync_err_out, cable_enabled_out;
  logic chain_clock_absent_err_out, chain_clock_halted_err_out;
  logic [1:0] role_in, role_out, follow_out, accept_out, run_out, hold_out;
  logic [2:0] cmd_in;
  logic [63:0] load_value_in, tick_value_out, posix_value_out, t, d;
  int num_errors, checked;

  ccs_chain_sync dut_u (
    .clock_in(clock_in), .rst_in(rst_in), .role_in(role_in), .cable_clk_in(cable_clk_in),
    .cable_clr_in(cable_clr_in), .cable_clk_out(cable_clk_out),
    .cable_clr_out(cable_clr_out), .sync_req_in(sync_req_in),
    .fwd_disable_in(fwd_disable_in), .fwd_enable_in(fwd_enable_in),
    .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .cmd_sel_in(cmd_sel_in),
    .load_value_in(load_value_in), .role_out(role_out), .sync_err_out(sync_err_out),
    .cable_enabled_out(cable_enabled_out),
    .chain_clock_absent_err_out(chain_clock_absent_err_out),
    .chain_clock_halted_err_out(chain_clock_halted_err_out), .follow_out(follow_out),
    .accept_out(accept_out), .run_out(run_out), .hold_out(hold_out),
    .tick_value_out(tick_value_out), .posix_value_out(posix_value_out)
  );
  ccs_up_board up_u (
    .run_in(up_run), .clr_req_in(up_clr),
    .cable_clk_out(cable_clk_in), .cable_clr_out(cable_clr_in)
  );

  always #10 clock_in = ~clock_in;

  // ==================================
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmd(input ccs_cmd_t c, input logic s, input logic [63:0] v);
    cmd_valid_in = 1'b1;
    cmd_in = c;
    cmd_sel_in = s;
    load_value_in = v;
    cyc(1);
    cmd_valid_in = 1'b0;
    // One idle edge so back-to-back calls never re-raise the strobe at once
    cyc(1);
  endtask
  // Order is sync, disable, enable
  task automatic pls(input logic [2:0] k);
    {sync_req_in, fwd_disable_in, fwd_enable_in} = k;
    cyc(1);
    {sync_req_in, fwd_disable_in, fwd_enable_in} = 3'h0;
  endtask
  // Bounded wait for a counter to move
  task automatic wchg(input bit p);
    logic [63:0] v;
    int i;
    v = p ? posix_value_out : tick_value_out;
    i = 0;
    while ((p ? posix_value_out : tick_value_out) === v) begin
      if (i == 60) begin
        num_errors++;
        end_of_test();
      end
      i++;
      cyc(1);
    end
  endtask

  // ==================================
  // Sequence
  initial begin
    clock_in = 1'b0;
    rst_in = 1'b1;
    {sync_req_in, fwd_disable_in, fwd_enable_in, cmd_valid_in, cmd_sel_in} = 5'h00;
    {up_run, up_clr} = 2'h0;
    role_in = 2'b00;
    cmd_in = CMD_NONE;
    load_value_in = 64'h0;
    cyc(2);
    chk({role_out, run_out, follow_out, accept_out, hold_out}, 10'h3fc);
    cyc(2);
    rst_in = 1'b0;
    cyc(4);
    chk(role_out, 2'b00);
    wchg(0);
    t = tick_value_out;
    cyc(19);
    chk(tick_value_out, t);
    cyc(1);
    chk(tick_value_out, t + 64'h1);
    cmd(CMD_UPDATE, 1'b0, 64'h0000_0000_0000_0100);
    chk(tick_value_out, 64'h0000_0000_0000_0100);
    cmd(CMD_UPDATE, 1'b1, {32'h0000_0005, NS_PER_SEC - NS_STEP});
    chk(posix_value_out, {32'h0000_0005, NS_PER_SEC - NS_STEP});
    wchg(1);
    chk(posix_value_out, 64'h0000_0006_0000_0000);
    cmd(CMD_STOP, 1'b0, 64'h0);
    chk(run_out, 2'b10);
    cyc(1);
    chk(tick_value_out, 64'h0);
    wchg(1);
    cmd(CMD_HOLD_ON, 1'b0, 64'h0);
    cmd(CMD_START, 1'b0, 64'h0);
    wchg(0);
    cmd(CMD_STOP, 1'b0, 64'h0);
    t = tick_value_out;
    cyc(30);
    chk(tick_value_out, t);
    chk(hold_out, 2'b01);
    cmd(CMD_START, 1'b0, 64'h0);
    cmd(CMD_HOLD_OFF, 1'b0, 64'h0);
    cmd(CMD_ISOLATE, 1'b0, 64'h0);
    chk({follow_out[0], accept_out[0]}, 2'b00);
    pls(3'b100);
    chk(tick_value_out == 64'h0, 1'b0);
    chk(posix_value_out, 64'h0);
    cyc(1);
    chk(cable_clr_out, 1'b1);
    cmd(CMD_CONNECT, 1'b0, 64'h0);
    pls(3'b100);
    chk(tick_value_out, 64'h0);
    chk(sync_err_out, 1'b0);
    pls(3'b010);
    cyc(1);
    chk({cable_enabled_out, chain_clock_halted_err_out}, 2'b01);
    cyc(2);
    t = tick_value_out;
    cyc(40);
    chk(tick_value_out, t);
    chk(cable_clk_out, 1'b0);
    pls(3'b001);
    cyc(1);
    chk(cable_enabled_out, 1'b1);
    wchg(0);
    // Slave: reset again so the absent timer starts clean
    role_in = 2'b01;
    rst_in = 1'b1;
    cyc(2);
    rst_in = 1'b0;
    cyc(90);
    chk(chain_clock_absent_err_out, 1'b1);
    chk(cable_enabled_out, 1'b0);
    pls(3'b100);
    chk(sync_err_out, 1'b1);
    chk(tick_value_out == 64'h0, 1'b0);
    up_run = 1'b1;
    cyc(10);
    chk(cable_enabled_out, 1'b1);
    t = tick_value_out;
    cyc(64);
    d = tick_value_out - t;
    chk(d >= 64'h7 && d <= 64'h9, 1'b1);
    up_clr = 1'b1;
    cyc(8);
    up_clr = 1'b0;
    chk(tick_value_out < 64'h3, 1'b1);
    up_run = 1'b0;
    cyc(100);
    chk(chain_clock_halted_err_out, 1'b1);
    end_of_test();
  end
endmodule // testbench
